// *** src/vff_pkg.sv ***
// Package: constants and carrier types for the rectified-voltage feed-forward block.
`default_nettype none
package vff_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 250;
	localparam int EDGE_LAT_NS = 10;
	// Longest latency rounds down to whole cycles.
	localparam int EDGE_LAT_CYC = (EDGE_LAT_NS * CLK_MHZ) / 1000;
	localparam int SETTLE_NS = 250;
	// Least settle time rounds up to whole cycles.
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

	// ****************************************
	// Widths and codes
	// ****************************************
	localparam int VW = 12;
	localparam int BW = 10;
	localparam int DW = 16;
	localparam int DFRAC = 12;
	localparam logic [1:0] FFSRC_VRECT = 2'h0;
	localparam logic [1:0] FFSRC_VIN = 2'h1;
	localparam logic [1:0] FFSRC_TLM = 2'h2;
	localparam logic [1:0] FFSRC_OVR = 2'h3;
	localparam logic [1:0] IIN_SRC_EST = 2'h2;
	localparam logic [1:0] MOD_TRAILING = 2'h2;
	localparam logic [1:0] LOOP_VMC = 2'h0;
	localparam logic DUTY_LOCK_OFF = 1'b0;
	localparam logic CMP_REF_500MV = 1'b0;
	localparam logic CMP_REF_300MV = 1'b1;
	localparam logic [VW-1:0] VZERO = 12'h000;
	localparam logic [DW-1:0] DZERO = 16'h0000;
	localparam logic [BW-1:0] BZERO = 10'h000;
	localparam logic [DW-1:0] DMAX = 16'hFFFF;

	typedef enum logic [1:0] {VFF_IDLE, VFF_BLANK, VFF_SAMPLE} vff_phase_t;

	typedef struct packed {
		logic [1:0] ff_src;
		logic ovr_sel;
		logic [VW-1:0] ovr_value;
		logic [VW-1:0] vin_init;
		logic [VW-1:0] vout_target;
		logic [VW-1:0] trans_scale;
		logic [VW-1:0] div_scale;
		logic [BW-1:0] blank_cycles;
		logic cmp_ref_sel;
		logic [1:0] iin_src;
		logic [1:0] mod_flavour;
		logic [1:0] loop_mode;
		logic duty_lock;
	} vff_cfg_t;

	typedef struct packed {
		logic cmp_ref;
		logic sample_open;
		logic rise_edge;
		logic fall_edge;
		logic [VW-1:0] held;
		logic held_valid;
		logic [DW-1:0] ff_term;
		logic [DW-1:0] duty;
		logic [VW-1:0] vin_est;
		logic voltage_mode_control;
		logic trailing;
		logic flux_bal_en;
		logic iin_est_only;
	} vff_stat_t;

	typedef struct packed {
		vff_phase_t phase;
		logic sense_q1;
		logic pwm_q1;
		logic [BW-1:0] blank_cnt;
		logic [VW-1:0] track;
		logic switched;
		vff_stat_t st;
	} vff_state_t;
endpackage : vff_pkg
`default_nettype wire

// *** src/vff_sense.sv ***
// Module: rectified-voltage edge sensing, sample hold and feed-forward duty.
`default_nettype none
// What this block does
// - Report rectified waveform rising and falling edges within 10 ns.
// - Comparator reference selectable between 500 mV and 300 mV.
// - A rising edge while idle starts a programmable blanking interval without sampling.
// - Sampling opens after blanking, closes when PWM output falls.
// - Tracking value follows ADC continuously while window is open.
// - Hold final sample at window close for next cycle feed-forward.
// - Before switching, use programmable initial input voltage.
// - Feed-forward duty is target divided by input voltage times scale.
// - Add feed-forward duty to PID output to form PWM duty.
// - Source select picks divisor; rectified sense gives target over held voltage.
// - Isolated uses rectified voltage, non-isolated uses input voltage.
// - Input voltage derives from held rectified reading times divider scale; turns ratio is not applied.
// - Voltage mode forces input current telemetry source code 2.
// - Modulation code 2 selects trailing-edge modulation.
// - Loop code 0 selects voltage mode; lock code 0 disables flux balance.
module vff_sense
	import vff_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic rect_sense_input,
	input wire logic [VW-1:0] adc_code,
	input wire logic pwm_out,
	input wire logic [VW-1:0] vin_telemetry,
	input wire logic [DW-1:0] pid_out,
	input wire vff_cfg_t cfg,
	output vff_stat_t stat
);
	vff_state_t s_q;
	vff_state_t s_d;
	logic [VW-1:0] divisor;
	logic [2*VW-1:0] denom;
	logic [DW+DFRAC-1:0] quot;
	logic [DW:0] sum;

	// ****************************************
	// Feed-forward arithmetic
	// ****************************************
	// A combinational divider keeps the answer within one cycle; it is the timing
	// hazard of this block and may need pipelining at speed.
	always_comb begin
		case (s_q.switched ? cfg.ff_src : FFSRC_OVR)
			FFSRC_VRECT: divisor = s_q.st.held;
			FFSRC_VIN: divisor = s_q.st.vin_est;
			FFSRC_TLM: divisor = vin_telemetry;
			default: divisor = s_q.switched ? cfg.ovr_value : cfg.vin_init;
		endcase
		if (cfg.ovr_sel && s_q.switched) begin
			divisor = cfg.ovr_value;
		end
		denom = divisor * cfg.trans_scale;
		if (denom == {(2*VW){1'b0}}) begin
			quot = {(DW+DFRAC){1'b1}};
		end else begin
			quot = ({cfg.vout_target, {(DW+DFRAC-VW){1'b0}}}) / (DW+DFRAC)'(denom);
		end
		sum = {1'b0, s_q.st.ff_term} + {1'b0, pid_out};
	end

	// ****************************************
	// Sequencing
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.sense_q1 = rect_sense_input;
		s_d.pwm_q1 = pwm_out;
		s_d.st.rise_edge = rect_sense_input && !s_q.sense_q1;
		s_d.st.fall_edge = !rect_sense_input && s_q.sense_q1;
		s_d.st.cmp_ref = cfg.cmp_ref_sel ? CMP_REF_300MV : CMP_REF_500MV;
		case (s_q.phase)
			VFF_IDLE: begin
				if (rect_sense_input && !s_q.sense_q1) begin
					s_d.phase = VFF_BLANK;
					s_d.blank_cnt = cfg.blank_cycles;
				end
			end
			VFF_BLANK: begin
				if (s_q.blank_cnt == BZERO) begin
					s_d.phase = VFF_SAMPLE;
					s_d.track = adc_code;
				end else begin
					s_d.blank_cnt = s_q.blank_cnt - 1'b1;
				end
			end
			VFF_SAMPLE: begin
				s_d.track = adc_code;
			end
			default: s_d.phase = VFF_IDLE;
		endcase
		// PWM falling edge ends the window and latches once per cycle.
		if (!pwm_out && s_q.pwm_q1) begin
			s_d.switched = 1'b1;
			if (s_q.phase == VFF_SAMPLE) begin
				s_d.st.held = s_q.track;
				s_d.st.held_valid = 1'b1;
			end
			s_d.phase = VFF_IDLE;
		end
		s_d.st.sample_open = (s_d.phase == VFF_SAMPLE);
		s_d.st.vin_est = VW'((32'(s_q.st.held) * 32'(cfg.div_scale)) >> VW);
		s_d.st.ff_term = (quot > (DW+DFRAC)'(DMAX)) ? DMAX : quot[DW-1:0];
		s_d.st.duty = sum[DW] ? DMAX : sum[DW-1:0];
		s_d.st.voltage_mode_control = (cfg.loop_mode == LOOP_VMC);
		s_d.st.flux_bal_en = (cfg.duty_lock != DUTY_LOCK_OFF);
		s_d.st.trailing = (cfg.mod_flavour == MOD_TRAILING);
		s_d.st.iin_est_only = (cfg.loop_mode == LOOP_VMC) || (cfg.iin_src == IIN_SRC_EST);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign stat = s_q.st;

	// A PWM fall is the only moment at which the held sample may move.
	logic pwm_fall;
	assign pwm_fall = s_q.pwm_q1 && !pwm_out;

	// ****************************************
	// Checks
	// ****************************************
	property p_edge_lat;
		@(posedge clock) disable iff (rst)
		$rose(rect_sense_input) |-> ##[1:2] stat.rise_edge;
	endproperty
	a_edge_lat: assert property (p_edge_lat) else $error("edge late");

	property p_blank;
		@(posedge clock) disable iff (rst)
		(s_q.phase == VFF_BLANK) |-> !stat.sample_open;
	endproperty
	a_blank: assert property (p_blank) else $error("sampling in blank");

	property p_close;
		@(posedge clock) disable iff (rst)
		$fell(pwm_out) |=> !stat.sample_open;
	endproperty
	a_close: assert property (p_close) else $error("window open after pwm fall");

	property p_hold;
		@(posedge clock) disable iff (rst)
		!$past(pwm_fall) |-> $stable(stat.held);
	endproperty
	a_hold: assert property (p_hold) else $error("held changed mid cycle");

	property p_latch;
		@(posedge clock) disable iff (rst)
		($fell(pwm_out) && s_q.phase == VFF_SAMPLE) |=> stat.held == $past(s_q.track);
	endproperty
	a_latch: assert property (p_latch) else $error("final sample not held");

	property p_sum;
		@(posedge clock) disable iff (rst)
		!sum[DW] |=> {1'b0, stat.duty} == $past(sum);
	endproperty
	a_sum: assert property (p_sum) else $error("duty not ff plus pid");

	property p_mode;
		@(posedge clock) disable iff (rst)
		(cfg.loop_mode == LOOP_VMC) |=> stat.voltage_mode_control && stat.iin_est_only;
	endproperty
	a_mode: assert property (p_mode) else $error("vmc flags wrong");

	property p_trail;
		@(posedge clock) disable iff (rst)
		(cfg.mod_flavour == MOD_TRAILING) |=> stat.trailing;
	endproperty
	a_trail: assert property (p_trail) else $error("trailing not set");

	property p_fall_lat;
		@(posedge clock) disable iff (rst)
		$fell(rect_sense_input) |-> ##[1:2] stat.fall_edge;
	endproperty
	a_fall_lat: assert property (p_fall_lat) else $error("fall edge late");

	property p_pulse;
		@(posedge clock) disable iff (rst)
		stat.rise_edge |=> !stat.rise_edge;
	endproperty
	a_pulse: assert property (p_pulse) else $error("edge pulse too long");

	property p_cmp;
		@(posedge clock) disable iff (rst)
		1'b1 |=> (stat.cmp_ref == CMP_REF_300MV) == $past(cfg.cmp_ref_sel);
	endproperty
	a_cmp: assert property (p_cmp) else $error("reference select not followed");

	property p_blank_start;
		@(posedge clock) disable iff (rst)
		(s_q.phase == VFF_IDLE && $rose(rect_sense_input) && !pwm_fall)
		|=> s_q.phase == VFF_BLANK && s_q.blank_cnt == $past(cfg.blank_cycles);
	endproperty
	a_blank_start: assert property (p_blank_start) else $error("blank not started");

	property p_open;
		@(posedge clock) disable iff (rst)
		(s_q.phase == VFF_BLANK && s_q.blank_cnt == BZERO && !pwm_fall) |=> stat.sample_open;
	endproperty
	a_open: assert property (p_open) else $error("window not opened after blank");

	property p_track;
		@(posedge clock) disable iff (rst)
		(s_q.phase == VFF_SAMPLE && !pwm_fall) |=> s_q.track == $past(adc_code);
	endproperty
	a_track: assert property (p_track) else $error("tracking value stale");

	property p_valid;
		@(posedge clock) disable iff (rst)
		(pwm_fall && s_q.phase == VFF_SAMPLE) |=> stat.held_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("held sample not marked valid");

	// Until the first PWM fall no sensed value exists, so the initial voltage must be used.
	property p_init;
		@(posedge clock) disable iff (rst)
		!s_q.switched |-> divisor == cfg.vin_init;
	endproperty
	a_init: assert property (p_init) else $error("initial voltage not used");

	property p_sat;
		@(posedge clock) disable iff (rst)
		sum[DW] |=> stat.duty == DMAX;
	endproperty
	a_sat: assert property (p_sat) else $error("duty not saturated");

	property p_flux;
		@(posedge clock) disable iff (rst)
		(cfg.duty_lock == DUTY_LOCK_OFF) |=> !stat.flux_bal_en;
	endproperty
	a_flux: assert property (p_flux) else $error("flux balance not disabled");
endmodule : vff_sense
`default_nettype wire

// *** testbench/vff_rect_model.sv ***
// Partner model: rectified-voltage comparator and tracking ADC across one switching pulse.
`default_nettype none
module vff_rect_model
	import vff_pkg::*;
(
	input wire logic clock,
	input wire logic start,
	input wire logic [VW-1:0] level,
	input wire logic [9:0] width,
	output logic rect,
	output logic [VW-1:0] adc,
	output logic pwm
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] cnt = 10'h000;
	initial begin
		rect = 1'b0;
		pwm = 1'b0;
		adc = VZERO;
	end
	// Between pulses the ADC line holds no valid sample, so it toggles to expose stale use.
	always @(posedge clock) begin
		if (start) begin
			rect <= 1'b1;
			pwm <= 1'b1;
			cnt <= width;
			adc <= level;
		end else if (cnt != 10'h000) begin
			cnt <= cnt - 10'h001;
			// The ADC follows the bench's level during the pulse, so mid-window moves are seen.
			adc <= level;
			if (cnt == 10'h003) begin
				pwm <= 1'b0;
				rect <= 1'b0;
			end
		end else begin
			adc <= ~adc;
		end
	end
endmodule : vff_rect_model
`default_nettype wire

// *** testbench/vff_sense_bench.sv ***
// Testbench: self-checking run of the rectified-voltage feed-forward block.
`default_nettype none
module vff_sense_bench;
	import vff_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic rect, pwm;
	logic [VW-1:0] adc, level = VZERO, vtel = VZERO;
	logic [9:0] width = 10'h000;
	logic [DW-1:0] pid = DZERO;
	vff_cfg_t cfg = '0;
	vff_stat_t stat;
	int fail_count = 0, checked = 0, cyc = 0, n;
	always #2 clock = ~clock;
	vff_sense vff_sense_i (.clock(clock), .rst(rst), .rect_sense_input(rect), .adc_code(adc),
		.pwm_out(pwm), .vin_telemetry(vtel), .pid_out(pid), .cfg(cfg), .stat(stat));
	vff_rect_model vff_rect_model_i (.clock(clock), .start(start), .level(level),
		.width(width), .rect(rect), .adc(adc), .pwm(pwm));
	task automatic results();
		if (fail_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input logic [47:0] seen, input logic [47:0] want);
		checked++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	function automatic logic [DW-1:0] exp_term(input logic [VW-1:0] v);
		logic [47:0] q;
		if (v * cfg.trans_scale == 0) return DMAX;
		q = {cfg.vout_target, 16'h0000} / (v * cfg.trans_scale);
		return (q > 48'hFFFF) ? DMAX : q[15:0];
	endfunction : exp_term
	function automatic logic [DW-1:0] exp_duty(input logic [DW-1:0] t);
		logic [16:0] s;
		s = {1'b0, pid} + {1'b0, t};
		return s[16] ? DMAX : s[15:0];
	endfunction : exp_duty
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick
	// ****************************************
	// Main sequence
	// ****************************************
	always @(posedge clock) if (++cyc > 20000) begin
		fail_count++;
		results();
	end
	initial begin
		void'($urandom(20));
		cfg.vin_init = 12'h100 + 12'($urandom % 1024);
		cfg.vout_target = 12'h001 + 12'($urandom % 1024);
		cfg.trans_scale = 12'h001 + 12'($urandom % 4);
		cfg.div_scale = 12'($urandom);
		cfg.blank_cycles = 10'(SETTLE_CYC + $urandom % 8);
		cfg.iin_src = IIN_SRC_EST;
		cfg.mod_flavour = MOD_TRAILING;
		cfg.loop_mode = LOOP_VMC;
		pid = 16'(($urandom % 2) ? 16'hFFF0 : $urandom % 4096);
		tick(20);
		chk(stat == '0, 1'b1);
		rst <= 1'b0;
		tick(4);
		chk(stat.ff_term, exp_term(cfg.vin_init));
		chk(stat.duty, exp_duty(exp_term(cfg.vin_init)));
		chk({stat.voltage_mode_control, stat.trailing, stat.flux_bal_en, stat.iin_est_only}, 4'hD);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			cfg.cmp_ref_sel <= i[0];
			level <= 12'h001 + 12'($urandom % 4095);
			width <= cfg.blank_cycles + 10'd30;
			start <= 1'b1;
			@(posedge clock);
			start <= 1'b0;
			n = 0;
			while (stat.rise_edge !== 1'b1 && n < 8) begin tick(1); n++; end
			chk(n <= EDGE_LAT_CYC, 1'b1);
			chk(stat.cmp_ref, i[0]);
			n = 0;
			while (stat.sample_open !== 1'b1 && n < 600) begin tick(1); n++; end
			chk(n, cfg.blank_cycles + 1);
			@(posedge clock);
			level <= (i == 1) ? VZERO : 12'h001 + 12'($urandom % 4095);
			while (pwm !== 1'b0 && n < 600) begin tick(1); n++; end
			tick(1);
			chk(stat.fall_edge, 1'b1);
			tick(2);
			chk(stat.sample_open, 1'b0);
			chk(stat.held, level);
			chk(stat.held_valid, 1'b1);
			chk(stat.vin_est, (24'(level) * 24'(cfg.div_scale)) >> 12);
			tick(30);
			chk(stat.held, level);
			chk(stat.ff_term, exp_term(level));
			chk(stat.duty, exp_duty(exp_term(level)));
		end
		@(posedge clock);
		cfg.ff_src <= FFSRC_VIN;
		tick(3);
		chk(stat.ff_term, exp_term(12'((24'(level) * 24'(cfg.div_scale)) >> 12)));
		@(posedge clock);
		cfg.ff_src <= FFSRC_TLM;
		vtel <= 12'h001 + 12'($urandom % 4095);
		tick(3);
		chk(stat.ff_term, exp_term(vtel));
		@(posedge clock);
		cfg.ff_src <= FFSRC_OVR;
		cfg.ovr_value <= 12'h001 + 12'($urandom % 4095);
		tick(3);
		chk(stat.ff_term, exp_term(cfg.ovr_value));
		chk(stat.duty, exp_duty(exp_term(cfg.ovr_value)));
		@(posedge clock);
		cfg.ff_src <= FFSRC_VRECT;
		cfg.ovr_sel <= 1'b1;
		tick(3);
		chk(stat.ff_term, exp_term(cfg.ovr_value));
		@(posedge clock);
		cfg.loop_mode <= 2'h1;
		cfg.mod_flavour <= 2'h0;
		cfg.duty_lock <= 1'b1;
		cfg.iin_src <= 2'h0;
		tick(2);
		chk({stat.voltage_mode_control, stat.trailing, stat.flux_bal_en, stat.iin_est_only}, 4'h2);
		@(posedge clock);
		cfg.iin_src <= IIN_SRC_EST;
		tick(2);
		chk(stat.iin_est_only, 1'b1);
		@(posedge clock);
		rst <= 1'b1;
		tick(2);
		chk(stat == '0, 1'b1);
		@(posedge clock);
		rst <= 1'b0;
		tick(4);
		chk(stat.ff_term, exp_term(cfg.vin_init));
		results();
	end
endmodule : vff_sense_bench
`default_nettype wire
